// ---- pkg/txdl_defines.vh ----
// constants for the transmit descriptor list download engine
`ifndef TXDL_DEFINES_VH
`define TXDL_DEFINES_VH
// register indices on the plain register port
`define TXDL_REG_LIST_PTR 4'h0
`define TXDL_REG_POLL 4'h1
`define TXDL_REG_CMD 4'h2
`define TXDL_REG_INT_STATUS 4'h3
`define TXDL_REG_INT_MASK 4'h4
`define TXDL_REG_ENG_STATE 4'h5
// command register bits
`define TXDL_CMD_HALT 0
`define TXDL_CMD_RESUME 1
`define TXDL_CMD_ENG_RESET 2
`define TXDL_CMD_CHIP_RESET 3
// interrupt status bits
`define TXDL_INT_DONE 0
`define TXDL_INT_STALLED 1
// descriptor layout, byte offsets from descriptor base
`define TXDL_OFF_LINK 32'h0000_0000
`define TXDL_OFF_HEADER 32'h0000_0004
`define TXDL_OFF_FRAG 32'h0000_0008
// fragment pair: address word after the length word, pairs two words apart
`define TXDL_FRAG_ADDR_OFF 32'h0000_0004
`define TXDL_FRAG_STRIDE 32'h0000_0008
// header word fields
`define TXDL_HDR_SKIP 31
`define TXDL_HDR_NOTIFY 30
`define TXDL_HDR_DONE 29
// fragment word: bit 31 marks the last fragment, low bits the length
`define TXDL_FRAG_LAST 31
`define TXDL_FRAG_LEN_W 16
`define TXDL_POLL_W 8
`endif

// ---- logic/txdl_engine.v ----
// transmit descriptor list download engine with register port and memory master
`timescale 1ns/100ps
`include "txdl_defines.vh"

module txdl_engine #(
  parameter AW = 32,
  parameter DW = 32,
  parameter POLL_UNIT = 16
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // register port
  input wire [3:0] reg_addr,
  input wire [DW-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [DW-1:0] reg_rdata,
  output reg irq,
  // host memory master, one request held until ack
  output reg mem_req,
  output reg mem_we,
  output reg [AW-1:0] mem_addr,
  output reg [DW-1:0] mem_wdata,
  input wire mem_ack,
  input wire [DW-1:0] mem_rdata,
  // fragment stream toward transmit fifo
  output reg frag_valid,
  output reg [AW-1:0] frag_addr,
  output reg [`TXDL_FRAG_LEN_W-1:0] frag_len,
  output reg frag_first,
  input wire frag_ready
);

  localparam ST_IDLE = 3'd0;
  localparam ST_HDR1 = 3'd1;
  localparam ST_FRAG = 3'd2;
  localparam ST_SEND = 3'd3;
  localparam ST_MARK = 3'd4;
  localparam ST_HOLD = 3'd5;
  localparam ST_HDR2 = 3'd6;
  localparam ST_LINK = 3'd7;

  reg [2:0] state_reg;
  reg [AW-1:0] list_ptr_reg;
  reg [AW-1:0] poll_addr_reg;
  reg polling_reg;
  reg [`TXDL_POLL_W-1:0] poll_ival_reg;
  reg [`TXDL_POLL_W+7:0] poll_cnt_reg;
  reg poll_kick_reg;
  reg stall_reg;
  reg [AW-1:0] frag_ptr_reg;
  reg first_frag_reg;
  reg last_frag_reg;
  reg [DW-1:0] hdr_reg;
  reg [1:0] int_status_reg;
  reg [1:0] int_mask_reg;
  reg skip_hdr;

  wire [2:0] cmd_bits;
  wire wr_cmd;
  wire eng_reset;
  wire [1:0] int_event;
  wire [`TXDL_POLL_W+7:0] poll_period;

  // decoder shared by read and write paths
  function is_reg;
    input [3:0] a;
    input [3:0] idx;
    begin
      is_reg = (a == idx);
    end
  endfunction

  assign wr_cmd = reg_wr && is_reg(reg_addr, `TXDL_REG_CMD);
  assign cmd_bits = wr_cmd ? reg_wdata[2:0] : 3'h0;
  assign eng_reset = wr_cmd && (reg_wdata[`TXDL_CMD_ENG_RESET] ||
    reg_wdata[`TXDL_CMD_CHIP_RESET]);
  assign poll_period = poll_ival_reg * POLL_UNIT[7:0];

  // register write side: poll interval and interrupt mask
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      poll_ival_reg <= 8'h00;
      int_mask_reg <= 2'h0;
    end else if (reg_wr) begin
      if (is_reg(reg_addr, `TXDL_REG_POLL))
        poll_ival_reg <= reg_wdata[`TXDL_POLL_W-1:0];
      if (is_reg(reg_addr, `TXDL_REG_INT_MASK))
        int_mask_reg <= reg_wdata[1:0];
    end
  end

  // halt and resume latch; a whole-chip reset also drops the halt
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stall_reg <= 1'b0;
    end else if (eng_reset) begin
      stall_reg <= 1'b0;
    end else if (cmd_bits[`TXDL_CMD_HALT]) begin
      stall_reg <= 1'b1;
    end else if (cmd_bits[`TXDL_CMD_RESUME]) begin
      stall_reg <= 1'b0;
    end
  end

  // poll timer: counts while idle polling; a pointer read kicks a poll early
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      poll_cnt_reg <= 16'h0000;
      poll_kick_reg <= 1'b0;
    end else begin
      if (reg_rd && is_reg(reg_addr, `TXDL_REG_LIST_PTR) && polling_reg)
        poll_kick_reg <= 1'b1;
      else if (state_reg == ST_LINK)
        poll_kick_reg <= 1'b0;
      if (state_reg != ST_IDLE || !polling_reg)
        poll_cnt_reg <= 16'h0000;
      else if (poll_cnt_reg < poll_period)
        poll_cnt_reg <= poll_cnt_reg + 16'h0001;
      else if (state_reg == ST_IDLE)
        poll_cnt_reg <= 16'h0000;
    end
  end

  always @* begin
    skip_hdr = mem_rdata[`TXDL_HDR_SKIP];
  end

  // engine sequencer and memory master
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      list_ptr_reg <= 32'h0000_0000;
      poll_addr_reg <= 32'h0000_0000;
      polling_reg <= 1'b0;
      frag_ptr_reg <= 32'h0000_0000;
      first_frag_reg <= 1'b0;
      last_frag_reg <= 1'b0;
      hdr_reg <= 32'h0000_0000;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      frag_valid <= 1'b0;
      frag_addr <= 32'h0000_0000;
      frag_len <= 16'h0000;
      frag_first <= 1'b0;
    end else if (eng_reset) begin
      // engine reset drops pointer, polling, request and fragment and leaves it idle
      state_reg <= ST_IDLE;
      list_ptr_reg <= 32'h0000_0000;
      polling_reg <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      frag_valid <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (reg_wr && is_reg(reg_addr, `TXDL_REG_LIST_PTR) &&
              list_ptr_reg == 32'h0000_0000 && reg_wdata != 32'h0000_0000) begin
            // pointer writes only land while the pointer is zero
            list_ptr_reg <= reg_wdata;
            polling_reg <= 1'b0;
          end else if (polling_reg && poll_ival_reg == 8'h00 && !poll_kick_reg) begin
            polling_reg <= 1'b0;
          end else if (polling_reg && !stall_reg &&
              (poll_kick_reg || poll_cnt_reg >= poll_period)) begin
            // re-read the same link entry
            state_reg <= ST_LINK;
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= poll_addr_reg + `TXDL_OFF_LINK;
          end else if (list_ptr_reg != 32'h0000_0000 && !stall_reg) begin
            // first header read of the descriptor
            state_reg <= ST_HDR1;
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= list_ptr_reg + `TXDL_OFF_HEADER;
            frag_ptr_reg <= list_ptr_reg + `TXDL_OFF_FRAG;
            first_frag_reg <= 1'b1;
          end
        end
        ST_HDR1: begin
          if (mem_ack) begin
            hdr_reg <= mem_rdata;
            mem_addr <= skip_hdr ? list_ptr_reg + `TXDL_OFF_LINK : frag_ptr_reg;
            state_reg <= skip_hdr ? ST_LINK : ST_FRAG;
          end
        end
        ST_FRAG: begin
          if (mem_ack) begin
            // fragment word: address word follows the length word
            if (first_frag_reg || !frag_valid) begin
              frag_len <= mem_rdata[`TXDL_FRAG_LEN_W-1:0];
              last_frag_reg <= mem_rdata[`TXDL_FRAG_LAST];
              mem_addr <= frag_ptr_reg + `TXDL_FRAG_ADDR_OFF;
              frag_ptr_reg <= frag_ptr_reg + `TXDL_FRAG_STRIDE;
              mem_req <= 1'b1;
              state_reg <= ST_SEND;
            end
          end
        end
        ST_SEND: begin
          if (mem_ack && !frag_valid) begin
            mem_req <= 1'b0;
            frag_addr <= mem_rdata;
            frag_first <= first_frag_reg;
            frag_valid <= 1'b1;
          end else if (frag_valid && frag_ready) begin
            frag_valid <= 1'b0;
            first_frag_reg <= 1'b0;
            mem_req <= 1'b1;
            if (last_frag_reg) begin
              // set done flag in header word
              state_reg <= ST_MARK;
              mem_we <= 1'b1;
              mem_addr <= list_ptr_reg + `TXDL_OFF_HEADER;
              mem_wdata <= hdr_reg | (32'h0000_0001 << `TXDL_HDR_DONE);
            end else begin
              state_reg <= ST_FRAG;
              mem_addr <= frag_ptr_reg;
            end
          end
        end
        ST_MARK: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // a pending halt takes effect here, on the packet boundary
          if (!stall_reg) begin
            state_reg <= ST_HDR2;
            mem_req <= 1'b1;
            mem_addr <= list_ptr_reg + `TXDL_OFF_HEADER;
          end
        end
        ST_HDR2: begin
          if (mem_ack) begin
            hdr_reg <= mem_rdata;
            state_reg <= ST_LINK;
            mem_addr <= list_ptr_reg + `TXDL_OFF_LINK;
          end
        end
        ST_LINK: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            state_reg <= ST_IDLE;
            if (mem_rdata != 32'h0000_0000) begin
              list_ptr_reg <= mem_rdata;
              polling_reg <= 1'b0;
            end else begin
              // zero link: idle, polling on this entry if enabled
              list_ptr_reg <= 32'h0000_0000;
              polling_reg <= (poll_ival_reg != 8'h00);
              if (!polling_reg)
                poll_addr_reg <= list_ptr_reg;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // sticky events; hardware set wins over a write-one clear
  assign int_event[`TXDL_INT_DONE] = state_reg == ST_HDR2 && mem_ack &&
    mem_rdata[`TXDL_HDR_NOTIFY];
  assign int_event[`TXDL_INT_STALLED] = state_reg == ST_MARK && mem_ack && stall_reg;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_status_reg <= 2'h0;
      irq <= 1'b0;
    end else begin
      if (reg_wr && is_reg(reg_addr, `TXDL_REG_INT_STATUS))
        int_status_reg <= (int_status_reg & ~reg_wdata[1:0]) | int_event;
      else
        int_status_reg <= int_status_reg | int_event;
      irq <= |(int_status_reg & int_mask_reg);
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `TXDL_REG_LIST_PTR: reg_rdata <= list_ptr_reg;
        `TXDL_REG_POLL: reg_rdata <= {24'h000000, poll_ival_reg};
        `TXDL_REG_INT_STATUS: reg_rdata <= {30'h00000000, int_status_reg};
        `TXDL_REG_INT_MASK: reg_rdata <= {30'h00000000, int_mask_reg};
        `TXDL_REG_ENG_STATE: reg_rdata <= {26'h0000000, stall_reg, polling_reg,
          (state_reg == ST_HOLD), state_reg};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // txdl_engine

// ---- verif/txdl_checker.sv ----
// port assertions for the download engine
`timescale 1ns/100ps
module txdl_checker (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire irq,
  // memory and fragment side
  input wire mem_req,
  input wire [31:0] mem_addr,
  input wire mem_ack,
  input wire frag_valid,
  input wire [31:0] frag_addr,
  input wire frag_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside answer");
  a_cmd_reads_zero: assert property ($past(reg_rd) && $past(reg_addr) == 4'h2 |-> reg_rdata == 32'h0)
    else $error("command register read not zero");
  a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > 4'h5 |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_req_held: assert property (mem_req && !mem_ack && !reg_wr && !$past(reg_wr)
    |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped early");
  a_frag_held: assert property (frag_valid && !frag_ready && !reg_wr && !$past(reg_wr)
    |=> frag_valid && $stable(frag_addr))
    else $error("fragment dropped early");
  a_reset_cmd_drop: assert property (reg_wr && reg_addr == 4'h2 && reg_wdata[3:2] != 2'b00
    |-> ##2 !mem_req)
    else $error("reset command left a request");
  a_reset_quiet: assert property ($past(sys_rst) |-> !mem_req && !frag_valid && !irq)
    else $error("outputs active after reset");
  a_irq_masked: assert property (reg_wr && reg_addr == 4'h4 && reg_wdata == 32'h0 |-> ##2 !irq)
    else $error("interrupt high with zero mask");
endmodule // txdl_checker
bind txdl_engine txdl_checker txdl_checker_inst (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq), .mem_req(mem_req), .mem_addr(mem_addr),
  .mem_ack(mem_ack), .frag_valid(frag_valid), .frag_addr(frag_addr), .frag_ready(frag_ready));

// ---- verif/txdl_mem_model.sv ----
// host memory model holding the descriptor lists
`timescale 1ns/100ps
module txdl_mem_model (
  // clock and fetch port
  input wire clk,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire slow,
  output logic mem_ack = 1'b0,
  output logic [31:0] mem_rdata = 32'h0
);
  logic [31:0] mem [0:255];
  logic [31:0] last_q = 32'h0;
  int wait_cnt = 0;
  // answers after one or four cycles; outside the answer the data lines
  // show the inverse of the last word, so stale data never looks valid
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~last_q;
    wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 1 : 0;
    if (mem_req && !mem_ack && wait_cnt >= (slow ? 3 : 0)) begin
      mem_ack <= 1'b1;
      if (mem_we) begin
        mem[mem_addr[9:2]] <= mem_wdata;
      end else begin
        mem_rdata <= mem[mem_addr[9:2]];
        last_q <= mem[mem_addr[9:2]];
      end
    end
  end
endmodule // txdl_mem_model

// ---- verif/tb_top.sv ----
// self-checking bench for the download engine
`timescale 1ns/100ps
module tb_top;
  logic clk = 0;
  logic sys_rst = 1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic frag_ready = 0;
  logic slow = 0;
  logic [31:0] d;
  wire [31:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, frag_addr;
  wire [15:0] frag_len;
  wire irq, mem_req, mem_we, mem_ack, frag_valid, frag_first;
  int fails = 0;
  int checks_done = 0;
  int reads = 0;
  int frags = 0;
  int cyc = 0;
  int t, t0, n;
  always #12.5 clk = ~clk;
  // cycle stamp plus counts of fetches and fragment handshakes
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mem_req && mem_ack && !mem_we) reads <= reads + 1;
    if (frag_valid && frag_ready) frags <= frags + 1;
  end
  txdl_engine txdl_engine_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .frag_valid(frag_valid), .frag_addr(frag_addr),
    .frag_len(frag_len), .frag_first(frag_first), .frag_ready(frag_ready));
  txdl_mem_model txdl_mem_model_inst (.clk(clk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .slow(slow), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // bounded wait: 0 fragment offered, 1 done flag in word w, 2 read of word w
  task automatic wait_on(input int sel, input int w, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clk);
      #1;
      if (sel == 0 && frag_valid === 1'b1) break;
      if (sel == 1 && txdl_mem_model_inst.mem[w][29] === 1'b1) break;
      if (sel == 2 && mem_req && mem_ack && !mem_we && mem_addr === w * 4) break;
    end
    t = cyc;
    if (i == lim) begin
      fails++;
      $display("mismatch at %0t: wait ran out", $time);
      end_of_test();
    end
  endtask
  task automatic desc(input int w, input logic [31:0] link, hdr, fa);
    txdl_mem_model_inst.mem[w] = link;
    txdl_mem_model_inst.mem[w + 1] = hdr;
    txdl_mem_model_inst.mem[w + 2] = 32'h8000_0010;
    txdl_mem_model_inst.mem[w + 3] = fa;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(4'h0);
    chk(d, 32'h0);
    rd(4'hf);
    chk(d, 32'h0);
    rd(4'h2);
    chk(d, 32'h0);
    // two chained packets, each halted after its done write; notify flips meanwhile
    desc(16, 32'h60, 32'h4000_0000, 32'h1000);
    desc(24, 32'h0, 32'h0, 32'h1001);
    wr(4'h4, 32'h1);
    wr(4'h0, 32'h40);
    for (int k = 0; k < 2; k++) begin
      slow <= (k == 1);
      wait_on(0, 0, 400);
      chk(frag_addr, 32'h1000 + k);
      chk({16'h0, frag_len}, 32'h10);
      chk({31'h0, frag_first}, 32'h1);
      wr(4'h2, 32'h1);
      frag_ready <= 1'b1;
      wait_on(1, 17 + 8 * k, 400);
      @(posedge clk);
      frag_ready <= 1'b0;
      wr(4'h0, 32'h300);
      rd(4'h0);
      chk(d, 32'h40 + 32'h20 * k);
      rd(4'h3);
      chk(d, 32'h2);
      rd(4'h5);
      chk(d[5:3], 3'h5);
      wr(4'h3, 32'h3);
      txdl_mem_model_inst.mem[17 + 8 * k][30] = (k == 1);
      wr(4'h2, 32'h2);
      wait_on(2, 16 + 8 * k, 400);
      rd(4'h3);
      chk(d, k);
      chk({31'h0, irq}, k);
      $display("packet test %0d done", k);
    end
    chk(txdl_mem_model_inst.mem[17], 32'h2000_0000);
    rd(4'h0);
    chk(d, 32'h0);
    wr(4'h4, 32'h0);
    rd(4'h3);
    chk(d, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(4'h3, 32'h1);
    rd(4'h3);
    chk(d, 32'h0);
    // dummy skip descriptor starts polling on an empty list
    // poll spacing window below assumes the one-cycle memory answer
    slow <= 1'b0;
    desc(48, 32'h0, 32'h8000_0000, 32'h0);
    wr(4'h1, 32'h2);
    wr(4'h0, 32'hc0);
    wait_on(2, 48, 100);
    t0 = t;
    wait_on(2, 48, 100);
    chk(t - t0 >= 32 && t - t0 <= 36, 32'h1);
    rd(4'h0);
    wait_on(2, 48, 10);
    chk(frags, 32'h2);
    chk({31'h0, frag_valid}, 32'h0);
    @(posedge clk);
    frag_ready <= 1'b1;
    desc(64, 32'h0, 32'h0, 32'h2000);
    txdl_mem_model_inst.mem[48] = 32'h100;
    wait_on(1, 65, 200);
    // let the engine fetch the final link and go idle before the pointer write
    wait_on(2, 64, 20);
    chk(frags, 32'h3);
    $display("polling test done");
    // engine and chip reset commands stop polling
    txdl_mem_model_inst.mem[48] = 32'h0;
    for (int b = 2; b < 4; b++) begin
      wr(4'h1, 32'h2);
      wr(4'h0, 32'hc0);
      wait_on(2, 48, 100);
      wr(4'h2, 32'h1 << b);
      n = reads;
      repeat (80) @(posedge clk);
      chk(reads - n, 32'h0);
      rd(4'h0);
      chk(d, 32'h0);
      $display("reset test %0d done", b);
    end
    end_of_test();
  end
endmodule // tb_top
